// file: pkg/eisc_pkg.sv
`default_nettype none
package eisc_pkg;

  // ==========================================================================
  // Register offsets (byte addresses on the plain register port)
  localparam logic [7:0] ADDR_PRIO_0 = 8'h24;
  localparam logic [7:0] ADDR_PRIO_1 = 8'h25;
  localparam logic [7:0] ADDR_PRIO_2 = 8'h26;
  localparam logic [7:0] ADDR_PRIO_3 = 8'h27;
  localparam logic [7:0] ADDR_CTRL = 8'h28;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h29;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h2a;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] PRIO_RESET = 8'hff;
  localparam logic [3:0] IRQ_RESET = 4'h0;

  // ==========================================================================
  // Control register fields
  localparam int CTRL_PB_SENSE_HI = 7;
  localparam int CTRL_PB_SENSE_LO = 6;
  localparam int CTRL_PB_INV = 5;
  localparam int CTRL_PAF_SENSE_HI = 4;
  localparam int CTRL_PAF_SENSE_LO = 3;
  localparam int CTRL_PA_INV = 2;
  localparam logic [7:0] CTRL_WRITABLE = 8'hfc;
  localparam logic [7:0] PRIO3_WRITABLE = 8'h0f;
  localparam logic [7:0] PRIO3_FIXED = 8'hf0;

  // ==========================================================================
  // Sensitivity encodings and masking level
  localparam logic [1:0] SENSE_FALL_LOW = 2'h0;
  localparam logic [1:0] SENSE_RISE = 2'h1;
  localparam logic [1:0] SENSE_FALL = 2'h2;
  localparam logic [1:0] SENSE_BOTH = 2'h3;
  localparam logic [1:0] MASK_LEVEL3 = 2'h3;
  localparam logic [1:0] PRIO_LEVEL0 = 2'h2;

  // ==========================================================================
  // Source indices
  localparam int SRC_PA = 0;
  localparam int SRC_PF = 1;
  localparam int SRC_PB = 2;
  localparam int SRC_PB4 = 3;
  localparam int NUM_SRC = 4;

endpackage
`default_nettype wire

// file: rtl/eisc_detect.sv
`timescale 1ns/1ns
`default_nettype none
module eisc_detect (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic pin_i,
  input wire logic [1:0] sense_i,
  input wire logic invert_i,
  output logic hit_o
);

  typedef struct packed {
    logic prev;
  } eisc_det_state_t;

  eisc_det_state_t st;
  eisc_det_state_t next_st;
  logic lvl;
  logic rise;
  logic fall;

  // ==========================================================================
  // Edge and level decode
  always_comb begin
    next_st.prev = pin_i;
    // Inversion flips the pin, so level, rising and falling encodings swap polarity; both edges is unchanged
    lvl = pin_i ^ invert_i;
    rise = (pin_i & ~st.prev) ^ (invert_i & (pin_i ^ st.prev));
    fall = (~pin_i & st.prev) ^ (invert_i & (pin_i ^ st.prev));
    case (sense_i)
      eisc_pkg::SENSE_FALL_LOW: hit_o = fall | ~lvl;
      eisc_pkg::SENSE_RISE: hit_o = rise;
      eisc_pkg::SENSE_FALL: hit_o = fall;
      eisc_pkg::SENSE_BOTH: hit_o = rise | fall;
      default: hit_o = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule
`default_nettype wire

// file: rtl/eisc_prio.sv
`timescale 1ns/1ns
`default_nettype none
module eisc_prio (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] writable_i,
  output logic [7:0] value_o
);

  typedef struct packed {
    logic [7:0] val;
  } eisc_prio_state_t;

  eisc_prio_state_t st;
  eisc_prio_state_t next_st;

  // ==========================================================================
  // Pairwise update; level 0 code keeps the old pair
  always_comb begin
    next_st = st;
    if (wr_i) begin
      for (int p = 0; p < 4; p++) begin
        if (wdata_i[2*p +: 2] != eisc_pkg::PRIO_LEVEL0 && writable_i[2*p]) begin
          next_st.val[2*p +: 2] = wdata_i[2*p +: 2];
        end
      end
    end
    value_o = st.val;
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st.val <= eisc_pkg::PRIO_RESET;
    end else begin
      st <= next_st;
    end
  end

endmodule
`default_nettype wire

// file: rtl/eisc_ctrl.sv
// Our own choice: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module eisc_ctrl (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic mask_level_hi_i,
  input wire logic mask_level_lo_i,
  input wire logic [3:0] src_porta_low_i,
  input wire logic [2:0] src_portf_i,
  input wire logic [3:0] src_portb_low_i,
  input wire logic src_portb_bit4_i,
  input wire logic [3:0] ack_i,
  output logic [3:0] pending_o,
  output logic irq_o
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic [7:0] ctrl;
    logic [3:0] pending;
    logic [3:0] status;
    logic [3:0] mask;
    logic [7:0] rdata;
    logic irq;
  } eisc_state_t;

  eisc_state_t st;
  eisc_state_t next_st;

  logic [3:0] hit;
  logic [3:0] src_pin;
  logic [7:0] prio0;
  logic [7:0] prio1;
  logic [7:0] prio2;
  logic [7:0] prio3;
  logic at_level3;
  logic ctrl_wr;
  logic [7:0] ctrl_new;

  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] reg_addr);
    addr_hit = (a == reg_addr);
  endfunction

  // ==========================================================================
  // Source pins: a group drives its source low when any of its pins is low
  // Pins within a group are combined by AND so a low level on any pin counts as the group low
  assign src_pin[eisc_pkg::SRC_PA] = &src_porta_low_i;
  assign src_pin[eisc_pkg::SRC_PF] = &src_portf_i;
  assign src_pin[eisc_pkg::SRC_PB] = &src_portb_low_i;
  assign src_pin[eisc_pkg::SRC_PB4] = src_portb_bit4_i;

  assign at_level3 = ({mask_level_hi_i, mask_level_lo_i} == eisc_pkg::MASK_LEVEL3);
  assign ctrl_wr = wr_i && addr_hit(addr_i, eisc_pkg::ADDR_CTRL);

  // ==========================================================================
  // Edge detectors per source
  eisc_detect u_det_pa (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .pin_i(src_pin[eisc_pkg::SRC_PA]),
    .sense_i(st.ctrl[eisc_pkg::CTRL_PAF_SENSE_HI:eisc_pkg::CTRL_PAF_SENSE_LO]),
    .invert_i(st.ctrl[eisc_pkg::CTRL_PA_INV]),
    .hit_o(hit[eisc_pkg::SRC_PA])
  );

  eisc_detect u_det_pf (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .pin_i(src_pin[eisc_pkg::SRC_PF]),
    .sense_i(st.ctrl[eisc_pkg::CTRL_PAF_SENSE_HI:eisc_pkg::CTRL_PAF_SENSE_LO]),
    .invert_i(1'b0),
    .hit_o(hit[eisc_pkg::SRC_PF])
  );

  eisc_detect u_det_pb (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .pin_i(src_pin[eisc_pkg::SRC_PB]),
    .sense_i(st.ctrl[eisc_pkg::CTRL_PB_SENSE_HI:eisc_pkg::CTRL_PB_SENSE_LO]),
    .invert_i(st.ctrl[eisc_pkg::CTRL_PB_INV]),
    .hit_o(hit[eisc_pkg::SRC_PB])
  );

  eisc_detect u_det_pb4 (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .pin_i(src_pin[eisc_pkg::SRC_PB4]),
    .sense_i(st.ctrl[eisc_pkg::CTRL_PB_SENSE_HI:eisc_pkg::CTRL_PB_SENSE_LO]),
    .invert_i(1'b0),
    .hit_o(hit[eisc_pkg::SRC_PB4])
  );

  // ==========================================================================
  // Software priority registers
  eisc_prio u_prio0 (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .wr_i(wr_i && addr_hit(addr_i, eisc_pkg::ADDR_PRIO_0)),
    .wdata_i(wdata_i),
    .writable_i(8'hff),
    .value_o(prio0)
  );

  eisc_prio u_prio1 (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .wr_i(wr_i && addr_hit(addr_i, eisc_pkg::ADDR_PRIO_1)),
    .wdata_i(wdata_i),
    .writable_i(8'hff),
    .value_o(prio1)
  );

  eisc_prio u_prio2 (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .wr_i(wr_i && addr_hit(addr_i, eisc_pkg::ADDR_PRIO_2)),
    .wdata_i(wdata_i),
    .writable_i(8'hff),
    .value_o(prio2)
  );

  // Upper nibble is hard wired to ones and never written
  eisc_prio u_prio3 (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .wr_i(wr_i && addr_hit(addr_i, eisc_pkg::ADDR_PRIO_3)),
    .wdata_i(wdata_i),
    .writable_i(eisc_pkg::PRIO3_WRITABLE),
    .value_o(prio3)
  );

  // ==========================================================================
  // Next state
  always_comb begin
    next_st = st;
    // Writes outside level 3 are dropped whole: a partial update could arm a
    // half-changed sensitivity while interrupts are live
    ctrl_new = wdata_i & eisc_pkg::CTRL_WRITABLE;
    if (ctrl_wr && at_level3) begin
      next_st.ctrl = ctrl_new;
    end
    // Requests latch until acknowledged; a new hit beats the acknowledge
    next_st.pending = (st.pending & ~ack_i) | hit;
    if (ctrl_wr && at_level3 && (ctrl_new != st.ctrl)) begin
      next_st.pending = 4'h0;
    end
    // Sticky status: set wins over a write-one-to-clear in the same cycle
    next_st.status = st.status | hit;
    if (wr_i && addr_hit(addr_i, eisc_pkg::ADDR_IRQ_STATUS)) begin
      next_st.status = (st.status & ~wdata_i[3:0]) | hit;
    end
    if (wr_i && addr_hit(addr_i, eisc_pkg::ADDR_IRQ_MASK)) begin
      next_st.mask = wdata_i[3:0];
    end
    next_st.irq = |(next_st.status & next_st.mask);
    next_st.rdata = 8'h00;
    if (rd_i) begin
      case (addr_i)
        eisc_pkg::ADDR_PRIO_0: next_st.rdata = prio0;
        eisc_pkg::ADDR_PRIO_1: next_st.rdata = prio1;
        eisc_pkg::ADDR_PRIO_2: next_st.rdata = prio2;
        eisc_pkg::ADDR_PRIO_3: next_st.rdata = prio3 | eisc_pkg::PRIO3_FIXED;
        eisc_pkg::ADDR_CTRL: next_st.rdata = st.ctrl;
        eisc_pkg::ADDR_IRQ_STATUS: next_st.rdata = {4'h0, st.status};
        eisc_pkg::ADDR_IRQ_MASK: next_st.rdata = {4'h0, st.mask};
        default: next_st.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st.ctrl <= eisc_pkg::CTRL_RESET;
      st.pending <= eisc_pkg::IRQ_RESET;
      st.status <= eisc_pkg::IRQ_RESET;
      st.mask <= eisc_pkg::IRQ_RESET;
      st.rdata <= 8'h00;
      st.irq <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign rdata_o = st.rdata;
  assign pending_o = st.pending;
  assign irq_o = st.irq;

  // ==========================================================================
  // Checks
  sequence s_ctrl_wr_locked;
    ctrl_wr && !at_level3;
  endsequence

  sequence s_ctrl_wr_change;
    ctrl_wr && at_level3 && (ctrl_new != st.ctrl);
  endsequence

  a_ctrl_write_lock: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    s_ctrl_wr_locked |=> $stable(st.ctrl))
    else $error("control changed outside mask level 3");

  a_ctrl_write_take: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    ctrl_wr && at_level3 |=> st.ctrl == ($past(wdata_i) & eisc_pkg::CTRL_WRITABLE))
    else $error("control write at level 3 not taken");

  a_reserved_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    st.ctrl[1:0] == 2'h0)
    else $error("reserved control bits not zero");

  a_pending_flush: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    s_ctrl_wr_change |=> pending_o == 4'h0)
    else $error("pending not cleared on changed control");

  a_pending_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    hit != 4'h0 && !ctrl_wr |=> (pending_o & $past(hit)) == $past(hit))
    else $error("detected request not latched");

  a_pb4_no_invert: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    st.ctrl[7:6] == eisc_pkg::SENSE_RISE && $rose(src_portb_bit4_i)
      |-> hit[eisc_pkg::SRC_PB4])
    else $error("port B bit 4 rising edge missed");

  a_pf_no_invert: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    st.ctrl[4:3] == eisc_pkg::SENSE_FALL && $fell(src_pin[eisc_pkg::SRC_PF])
      |-> hit[eisc_pkg::SRC_PF])
    else $error("port F falling edge missed");

  a_pa_inverted: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    st.ctrl[4:2] == 3'h1 && src_pin[eisc_pkg::SRC_PA] |-> hit[eisc_pkg::SRC_PA])
    else $error("inverted high level not detected");

  a_pb_level_low: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    st.ctrl[7:5] == 3'h0 && !src_pin[eisc_pkg::SRC_PB] |-> hit[eisc_pkg::SRC_PB])
    else $error("low level not detected");

  a_irq_follows: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    irq_o == |(st.status & st.mask))
    else $error("interrupt output disagrees with status and mask");

  // ==========================================================================
  // Interrupt, register and further detection checks
  sequence s_unmasked_hit;
    (hit & st.mask) != 4'h0 && !(wr_i && (addr_i == eisc_pkg::ADDR_IRQ_MASK));
  endsequence

  sequence s_status_w1c;
    wr_i && (addr_i == eisc_pkg::ADDR_IRQ_STATUS);
  endsequence

  a_irq_raise: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    s_unmasked_hit |=> irq_o)
    else $error("unmasked request did not raise the interrupt");

  a_status_set_wins: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    s_status_w1c |=> (st.status & $past(hit)) == $past(hit))
    else $error("status clear beat a new event");

  a_status_w1c: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    s_status_w1c |=> (st.status & $past(wdata_i[3:0]) & ~$past(hit)) == 4'h0)
    else $error("status bit not cleared by writing one");

  a_status_sticky: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    !(wr_i && (addr_i == eisc_pkg::ADDR_IRQ_STATUS))
      |=> (st.status & $past(st.status)) == $past(st.status))
    else $error("status bit dropped without a clear");

  a_pending_ack: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    !ctrl_wr |=> (pending_o & $past(ack_i) & ~$past(hit)) == 4'h0)
    else $error("acknowledged request still pending");

  a_pending_no_spur: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    !ctrl_wr |=> (pending_o & ~$past(st.pending) & ~$past(hit)) == 4'h0)
    else $error("request pending without a detected event");

  a_prio_level0_keep: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    wr_i && (addr_i == eisc_pkg::ADDR_PRIO_0) && (wdata_i[5:4] == eisc_pkg::PRIO_LEVEL0)
      |=> prio0[5:4] == $past(prio0[5:4]))
    else $error("level 0 priority code was stored");

  a_prio_pair_take: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    wr_i && (addr_i == eisc_pkg::ADDR_PRIO_1) && (wdata_i[7:6] != eisc_pkg::PRIO_LEVEL0)
      |=> prio1[7:6] == $past(wdata_i[7:6]))
    else $error("priority pair write not taken");

  a_prio3_fixed: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    rd_i && (addr_i == eisc_pkg::ADDR_PRIO_3) |=> (rdata_o & eisc_pkg::PRIO3_FIXED) == eisc_pkg::PRIO3_FIXED)
    else $error("fixed priority bits not read as ones");

  a_rdata_idle: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    !rd_i |=> rdata_o == 8'h00)
    else $error("read data not zero outside a read");

  a_ctrl_read_back: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    rd_i && (addr_i == eisc_pkg::ADDR_CTRL) |=> rdata_o == $past(st.ctrl))
    else $error("control read data wrong");

  a_pb_inv_high: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    st.ctrl[7:5] == 3'h1 && src_pin[eisc_pkg::SRC_PB] |-> hit[eisc_pkg::SRC_PB])
    else $error("port B inverted high level not detected");

  a_pb_inv_fall: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    st.ctrl[7:5] == 3'h3 && $fell(src_pin[eisc_pkg::SRC_PB]) |-> hit[eisc_pkg::SRC_PB])
    else $error("port B inverted falling edge missed");

  a_pb4_level_low: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    st.ctrl[7:5] == 3'h1 && !src_portb_bit4_i |-> hit[eisc_pkg::SRC_PB4])
    else $error("port B bit 4 low level missed under inversion");

  a_pf_level_low: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    st.ctrl[4:2] == 3'h1 && !src_pin[eisc_pkg::SRC_PF] |-> hit[eisc_pkg::SRC_PF])
    else $error("port F low level missed under inversion");

  a_pa_both_edges: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    st.ctrl[4:3] == eisc_pkg::SENSE_BOTH && $changed(src_pin[eisc_pkg::SRC_PA])
      |-> hit[eisc_pkg::SRC_PA])
    else $error("port A edge missed in both edge mode");

  a_pa_fall_only: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    st.ctrl[4:2] == 3'h4 && $stable(src_pin[eisc_pkg::SRC_PA])
      |-> !hit[eisc_pkg::SRC_PA])
    else $error("port A request without an edge");

  a_pa_inv_rise: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    st.ctrl[4:2] == 3'h5 && $rose(src_pin[eisc_pkg::SRC_PA])
      |-> hit[eisc_pkg::SRC_PA])
    else $error("port A inverted rising edge missed");

endmodule
`default_nettype wire

// file: testbench/eisc_pins_model.sv
`timescale 1ns/1ns
`default_nettype none
module eisc_pins_model (
  input wire logic [3:0] level_i,
  input wire logic [31:0] rnd_i,
  input wire logic ack_req_i,
  output logic [3:0] src_porta_low_o,
  output logic [2:0] src_portf_o,
  output logic [3:0] src_portb_low_o,
  output logic src_portb_bit4_o,
  output logic [3:0] ack_o
);
  // ==========
  // Pins and service acknowledge
  logic [3:0] low;
  always_comb begin
    // Low group keeps one pin low but shuffles the rest every cycle
    low = rnd_i[3:0] & ~(4'h1 << rnd_i[5:4]);
    src_porta_low_o = level_i[0] ? 4'hf : low;
    src_portf_o = level_i[1] ? 3'h7 : low[2:0] & ~3'h1;
    src_portb_low_o = level_i[2] ? 4'hf : {low[0], low[3:1]};
    src_portb_bit4_o = level_i[3];
    ack_o = {4{ack_req_i}};
  end
endmodule
`default_nettype wire

// file: testbench/ext_irq_sensitivity_ctrl_bench.sv
`timescale 1ns/1ns
`default_nettype none
module ext_irq_sensitivity_ctrl_bench;
  // ==========
  // Signals
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [1:0] lvl = 2'h0;
  logic [3:0] level = 4'hf;
  logic ack_req = 1'b0;
  logic [31:0] rnd = 32'h668a;
  logic [7:0] rdata;
  logic [7:0] prio [4];
  logic [3:0] pa, pb, ack, pending;
  logic [2:0] pf;
  logic pb4, irq;
  int miscompares = 0;
  int checked = 0;

  always #5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) rnd <= lfsr(rnd);

  eisc_ctrl i_eisc_ctrl (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .mask_level_hi_i(lvl[1]),
    .mask_level_lo_i(lvl[0]), .src_porta_low_i(pa), .src_portf_i(pf),
    .src_portb_low_i(pb), .src_portb_bit4_i(pb4), .ack_i(ack), .pending_o(pending),
    .irq_o(irq));
  eisc_pins_model i_eisc_pins_model (.level_i(level), .rnd_i(rnd), .ack_req_i(ack_req),
    .src_porta_low_o(pa), .src_portf_o(pf), .src_portb_low_o(pb),
    .src_portb_bit4_o(pb4), .ack_o(ack));

  // ==========
  // Expectations
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [7:0] pexp(input logic [7:0] o, w, m);
    logic [7:0] r;
    r = o;
    for (int p = 0; p < 4; p++) begin
      if (w[2*p+:2] != eisc_pkg::PRIO_LEVEL0) begin
        r[2*p+:2] = w[2*p+:2];
      end
    end
    return (r & m) | ~m;
  endfunction
  function automatic logic det(input logic [1:0] s, input logic iv, p, c);
    logic r, f;
    r = iv ? (p & ~c) : (~p & c);
    f = iv ? (~p & c) : (p & ~c);
    case (s)
      eisc_pkg::SENSE_FALL_LOW: return f | (c == iv);
      eisc_pkg::SENSE_RISE: return r;
      eisc_pkg::SENSE_FALL: return f;
      default: return r | f;
    endcase
  endfunction
  // Bit 3 and bit 1 sources never invert
  function automatic logic [3:0] ev(input logic [1:0] s, input logic iv, p, c);
    return {det(s, 1'b0, p, c), det(s, iv, p, c), det(s, 1'b0, p, c), det(s, iv, p, c)};
  endfunction

  // ==========
  // Bus and check tasks
  task automatic chk(input logic [7:0] g, e);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic wr_reg(input logic [7:0] a, d);
    @(posedge clk_sys_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys_i);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, e);
    @(posedge clk_sys_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_i);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic summarize();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ==========
  // Scenarios
  initial begin
    logic [1:0] a, s;
    logic [7:0] d;
    logic [3:0] e;
    logic iv, b;
    cyc(20);
    rst_b_i <= 1'b1;
    rd_reg(eisc_pkg::ADDR_CTRL, 8'h00);
    for (int i = 0; i < 4; i++) begin
      prio[i] = eisc_pkg::PRIO_RESET;
      rd_reg(eisc_pkg::ADDR_PRIO_0 + 8'(i), prio[i]);
    end
    for (int l = 0; l < 3; l++) begin
      @(posedge clk_sys_i) lvl <= 2'(l);
      wr_reg(eisc_pkg::ADDR_CTRL, 8'hfc);
      rd_reg(eisc_pkg::ADDR_CTRL, 8'h00);
    end
    @(posedge clk_sys_i) lvl <= eisc_pkg::MASK_LEVEL3;
    wr_reg(eisc_pkg::ADDR_PRIO_0, 8'hcf);
    wr_reg(eisc_pkg::ADDR_PRIO_0, 8'h64);
    prio[0] = 8'h44;
    rd_reg(eisc_pkg::ADDR_PRIO_0, prio[0]);
    repeat (12) begin
      a = rnd[1:0];
      d = rnd[15:8];
      prio[a] = pexp(prio[a], d, a == 2'h3 ? eisc_pkg::PRIO3_WRITABLE : 8'hff);
      wr_reg(eisc_pkg::ADDR_PRIO_0 + 8'(a), d);
      rd_reg(eisc_pkg::ADDR_PRIO_0 + 8'(a), prio[a]);
    end
    repeat (6) begin
      // Software keeps the reserved pair clear
      d = rnd[7:0] & eisc_pkg::CTRL_WRITABLE;
      wr_reg(eisc_pkg::ADDR_CTRL, d);
      rd_reg(eisc_pkg::ADDR_CTRL, d);
    end
    rd_reg(8'h30, 8'h00);
    for (int k = 0; k < 16; k++) begin
      s = 2'(k >> 2);
      iv = k[1];
      b = k[0];
      wr_reg(eisc_pkg::ADDR_CTRL, {s, iv, s, iv, 2'h0});
      @(posedge clk_sys_i) level <= {4{b}};
      cyc(3);
      ack_req <= 1'b1;
      cyc(1);
      ack_req <= 1'b0;
      cyc(2);
      e = ev(s, iv, b, b);
      #1 chk({4'h0, pending}, {4'h0, e});
      @(posedge clk_sys_i) level <= {4{~b}};
      cyc(3);
      e = e | ev(s, iv, b, ~b) | ev(s, iv, ~b, ~b);
      #1 chk({4'h0, pending}, {4'h0, e});
    end
    @(posedge clk_sys_i) level <= 4'hf;
    wr_reg(eisc_pkg::ADDR_CTRL, 8'h90);
    wr_reg(eisc_pkg::ADDR_IRQ_STATUS, 8'h0f);
    wr_reg(eisc_pkg::ADDR_IRQ_MASK, 8'h00);
    @(posedge clk_sys_i) level <= 4'h0;
    cyc(3);
    rd_reg(eisc_pkg::ADDR_IRQ_STATUS, 8'h0f);
    chk({7'h0, irq}, 8'h00);
    wr_reg(eisc_pkg::ADDR_IRQ_MASK, 8'h01);
    cyc(1);
    #1 chk({7'h0, irq}, 8'h01);
    wr_reg(eisc_pkg::ADDR_IRQ_STATUS, 8'h01);
    cyc(1);
    #1 chk({7'h0, irq}, 8'h00);
    rd_reg(eisc_pkg::ADDR_IRQ_STATUS, 8'h0e);
    // Same value must not drop what is already pending
    wr_reg(eisc_pkg::ADDR_CTRL, 8'h90);
    cyc(2);
    #1 chk({4'h0, pending}, 8'h0f);
    wr_reg(eisc_pkg::ADDR_CTRL, 8'h98);
    cyc(2);
    #1 chk({4'h0, pending}, 8'h00);
    summarize();
  end

  initial begin
    cyc(20000);
    miscompares++;
    summarize();
  end
endmodule
`default_nettype wire
